// ### ddp_map.svh
`ifndef DDP_MAP_SVH
`define DDP_MAP_SVH

// clock period of i_clock in ns
`define DDP_CLK_PERIOD_NS 20
// least times on the pins, in ns
`define DDP_T_SETUP_NS 20
`define DDP_T_WR_LOW_NS 40
`define DDP_T_HOLD_NS 20
`define DDP_T_RD_LOW_NS 120
`define DDP_T_TURN_NS 40

// least times rounded up to whole cycles
`define DDP_SETUP_CYC ((`DDP_T_SETUP_NS + `DDP_CLK_PERIOD_NS - 1) / `DDP_CLK_PERIOD_NS)
`define DDP_WR_LOW_CYC ((`DDP_T_WR_LOW_NS + `DDP_CLK_PERIOD_NS - 1) / `DDP_CLK_PERIOD_NS)
`define DDP_HOLD_CYC ((`DDP_T_HOLD_NS + `DDP_CLK_PERIOD_NS - 1) / `DDP_CLK_PERIOD_NS)
`define DDP_RD_LOW_CYC ((`DDP_T_RD_LOW_NS + `DDP_CLK_PERIOD_NS - 1) / `DDP_CLK_PERIOD_NS)
`define DDP_TURN_CYC ((`DDP_T_TURN_NS + `DDP_CLK_PERIOD_NS - 1) / `DDP_CLK_PERIOD_NS)

// least select-low cycles so a read word has crossed the pin synchroniser
`define DDP_RD_MIN_CYC 5
// width of the phase counter
`define DDP_CNT_W 8
// word width on the data lines
`define DDP_WORD_W 12
// reset value of the readback word
`define DDP_RDATA_RST 12'h000

`endif

// ### ddp_pkg.sv
package ddp_pkg;

	// access phases, one-hot
	typedef enum logic [3:0] {
		DDP_IDLE = 4'h1,
		DDP_SETUP = 4'h2,
		DDP_STROBE = 4'h4,
		DDP_HOLD = 4'h8
	} ddp_state_e;

endpackage : ddp_pkg

// ### ddp_pin_sync.sv
`timescale 1ns/10ps
`include "ddp_map.svh"

module ddp_pin_sync #(
	parameter int WIDTH = `DDP_WORD_W
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("ddp_pin_sync: WIDTH must be at least 1");
		end
	endgenerate

	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			logic s1_r, s2_r, s3_r, level_r;
			logic s1_nxt, s2_nxt, s3_nxt, level_nxt;

			// three stages, the level moves once the last two agree
			always_comb begin
				s1_nxt = i_pin[b];
				s2_nxt = s1_r;
				s3_nxt = s2_r;
				level_nxt = (s2_r == s3_r) ? s3_r : level_r;
			end

			always_ff @(posedge i_clock or negedge i_resetn) begin
				if (!i_resetn) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					level_r <= 1'b0;
				end else begin
					s1_r <= s1_nxt;
					s2_r <= s2_nxt;
					s3_r <= s3_nxt;
					level_r <= level_nxt;
				end
			end

			assign o_level[b] = level_r;
		end
	endgenerate

endmodule : ddp_pin_sync

// ### ddp_host_port.sv
`timescale 1ns/10ps
`include "ddp_map.svh"

module ddp_host_port #(
	parameter int DATA_W = `DDP_WORD_W
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	// user side
	input wire logic i_req,
	input wire logic i_req_read,
	input wire logic i_req_chan,
	input wire logic [DATA_W-1:0] i_req_word,
	output logic o_ready,
	output logic o_done,
	output logic [DATA_W-1:0] o_read_word,
	// device pins
	output logic o_select_a_n,
	output logic o_select_b_n,
	output logic o_read_not_write,
	input wire logic [DATA_W-1:0] i_data_lines,
	output logic [DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe_n
);

	localparam logic [`DDP_CNT_W-1:0] SETUP_CYC = `DDP_CNT_W'(`DDP_SETUP_CYC);
	localparam logic [`DDP_CNT_W-1:0] WR_LOW_CYC = `DDP_CNT_W'(`DDP_WR_LOW_CYC);
	localparam logic [`DDP_CNT_W-1:0] HOLD_CYC = `DDP_CNT_W'(`DDP_HOLD_CYC);
	localparam logic [`DDP_CNT_W-1:0] RD_LOW_CYC = `DDP_CNT_W'(`DDP_RD_LOW_CYC);
	localparam logic [`DDP_CNT_W-1:0] TURN_CYC = `DDP_CNT_W'(`DDP_TURN_CYC);
	localparam logic [`DDP_CNT_W-1:0] ONE = `DDP_CNT_W'(1);

	// elaboration checks
	generate
		if (DATA_W != `DDP_WORD_W) begin : g_bad_width
			$error("ddp_host_port: DATA_W must equal the device word width");
		end
		if (`DDP_RD_LOW_CYC < `DDP_RD_MIN_CYC) begin : g_bad_read
			$error("ddp_host_port: read strobe shorter than the pin synchroniser");
		end
		if (`DDP_RD_LOW_CYC > 255 || `DDP_TURN_CYC > 255 || `DDP_WR_LOW_CYC > 255) begin : g_big
			$error("ddp_host_port: phase count exceeds the counter");
		end
		// a zero count would wrap the down-counter to its top value
		if (`DDP_SETUP_CYC < 1 || `DDP_WR_LOW_CYC < 1 ||
				`DDP_HOLD_CYC < 1 || `DDP_TURN_CYC < 1) begin : g_zero
			$error("ddp_host_port: every phase needs at least one cycle");
		end
	endgenerate

	ddp_pkg::ddp_state_e state_r, state_nxt;
	logic [`DDP_CNT_W-1:0] cnt_r, cnt_nxt;
	logic is_read_r, is_read_nxt;
	logic chan_r, chan_nxt;
	logic ready_r, ready_nxt;
	logic done_r, done_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic strobe_on, strobe_off; // select fall and rise requests from the sequencer
	wire [1:0] sel_n;
	logic rnw_r, rnw_nxt;
	logic [DATA_W-1:0] dout_r, dout_nxt;
	logic oe_n_r, oe_n_nxt;
	logic [DATA_W-1:0] data_level;

	// data lines arrive from the pins through three stages and a level flop
	ddp_pin_sync #(
		.WIDTH(DATA_W)
	) u_data_sync (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_pin(i_data_lines),
		.o_level(data_level)
	);

	// access sequencer: setup, select low, select high with hold
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		is_read_nxt = is_read_r;
		chan_nxt = chan_r;
		ready_nxt = ready_r;
		done_nxt = 1'b0;
		rdata_nxt = rdata_r;
		strobe_on = 1'b0;
		strobe_off = 1'b0;
		rnw_nxt = rnw_r;
		dout_nxt = dout_r;
		oe_n_nxt = oe_n_r;
		case (state_r)
			ddp_pkg::DDP_IDLE: begin
				if (i_req) begin
					is_read_nxt = i_req_read;
					chan_nxt = i_req_chan;
					dout_nxt = i_req_word;
					ready_nxt = 1'b0;
					rnw_nxt = i_req_read;
					oe_n_nxt = i_req_read; // released for a readback
					cnt_nxt = SETUP_CYC - ONE;
					state_nxt = ddp_pkg::DDP_SETUP;
				end
			end
			ddp_pkg::DDP_SETUP: begin
				if (cnt_r == '0) begin
					strobe_on = 1'b1;
					cnt_nxt = is_read_r ? RD_LOW_CYC - ONE : WR_LOW_CYC - ONE;
					state_nxt = ddp_pkg::DDP_STROBE;
				end else begin
					cnt_nxt = cnt_r - ONE;
				end
			end
			ddp_pkg::DDP_STROBE: begin
				if (cnt_r == '0) begin
					if (is_read_r) begin
						rdata_nxt = data_level;
					end
					strobe_off = 1'b1;
					cnt_nxt = is_read_r ? TURN_CYC - ONE : HOLD_CYC - ONE;
					state_nxt = ddp_pkg::DDP_HOLD;
				end else begin
					cnt_nxt = cnt_r - ONE;
				end
			end
			ddp_pkg::DDP_HOLD: begin
				if (cnt_r == '0) begin
					oe_n_nxt = 1'b1;
					rnw_nxt = 1'b1;
					done_nxt = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = ddp_pkg::DDP_IDLE;
				end else begin
					cnt_nxt = cnt_r - ONE;
				end
			end
			default: begin
				strobe_off = 1'b1;
				rnw_nxt = 1'b1;
				oe_n_nxt = 1'b1;
				ready_nxt = 1'b1;
				state_nxt = ddp_pkg::DDP_IDLE;
			end
		endcase
	end

	// sequencer registers; bus released and selects high in reset
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= ddp_pkg::DDP_IDLE;
			cnt_r <= '0;
			is_read_r <= 1'b0;
			chan_r <= 1'b0;
			ready_r <= 1'b1;
			done_r <= 1'b0;
			rdata_r <= `DDP_RDATA_RST;
			rnw_r <= 1'b1;
			dout_r <= '0;
			oe_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			is_read_r <= is_read_nxt;
			chan_r <= chan_nxt;
			ready_r <= ready_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
			rnw_r <= rnw_nxt;
			dout_r <= dout_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// one select flop per channel; only the decoded one may fall
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic sel_n_r, sel_n_nxt;

			always_comb begin
				sel_n_nxt = sel_n_r;
				if (strobe_off) begin
					sel_n_nxt = 1'b1; // rising edge ends the access
				end else if (strobe_on && (chan_r == 1'(ch))) begin
					sel_n_nxt = 1'b0;
				end
			end

			// high in reset, one fall and rise per word
			always_ff @(posedge i_clock or negedge i_resetn) begin
				if (!i_resetn) begin
					sel_n_r <= 1'b1;
				end else begin
					sel_n_r <= sel_n_nxt;
				end
			end

			assign sel_n[ch] = sel_n_r;
		end
	endgenerate

	// outputs straight from flops
	assign o_ready = ready_r;
	assign o_done = done_r;
	assign o_read_word = rdata_r;
	assign o_select_a_n = sel_n[0];
	assign o_select_b_n = sel_n[1];
	assign o_read_not_write = rnw_r;
	assign o_data_lines = dout_r;
	assign o_data_lines_oe_n = oe_n_r;

endmodule : ddp_host_port

// ### ddp_host_port_asserts.sv
`timescale 1ns/10ps
module ddp_host_port_asserts #(
	parameter int DATA_W = 12
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire logic i_req_read,
	input wire logic o_ready,
	input wire logic o_done,
	input wire logic o_select_a_n,
	input wire logic o_select_b_n,
	input wire logic o_read_not_write,
	input wire logic [DATA_W-1:0] o_data_lines,
	input wire logic o_data_lines_oe_n
);
	// either channel selected
	wire sel_low = !o_select_a_n || !o_select_b_n;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// pin sequencing and answer latency
	property p_one_sel; !(!o_select_a_n && !o_select_b_n); endproperty
	a_one_sel: assert property (p_one_sel) else $error("both selects low");
	property p_wr_drive; sel_low && !o_read_not_write |-> !o_data_lines_oe_n; endproperty
	a_wr_drive: assert property (p_wr_drive) else $error("write without drive");
	property p_rd_free; o_read_not_write |-> o_data_lines_oe_n; endproperty
	a_rd_free: assert property (p_rd_free) else $error("host drives in read");
	property p_wr_word; sel_low && !o_read_not_write |-> $stable(o_data_lines); endproperty
	a_wr_word: assert property (p_wr_word) else $error("word moved in write");
	property p_wr_pulse; $rose(sel_low) && !o_read_not_write |-> sel_low[*2] ##1 !sel_low;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write select width");
	property p_rd_pulse; $rose(sel_low) && o_read_not_write |-> sel_low[*6] ##1 !sel_low;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read select width");
	// done is sampled high one cycle more than setup plus strobe plus hold cycles after the taking edge
	property p_wr_done; o_ready && i_req && !i_req_read |-> ##5 o_done; endproperty
	a_wr_done: assert property (p_wr_done) else $error("write done late");
	property p_rd_done; o_ready && i_req && i_req_read |-> ##10 o_done; endproperty
	a_rd_done: assert property (p_rd_done) else $error("read done late");
endmodule : ddp_host_port_asserts

// ### ddp_dac_model.sv
`timescale 1ns/10ps
module ddp_dac_model (
	input wire logic i_select_a_n,
	input wire logic i_select_b_n,
	input wire logic i_read_not_write,
	input wire logic [11:0] i_data_lines,
	output logic [11:0] o_data_lines,
	output logic o_drive
);
	logic [11:0] in_r = 12'h000;
	logic [11:0] reg_a = 12'h000;
	logic [11:0] reg_b = 12'h000;
	int loads = 0;
	always @* begin
		if (!(i_select_a_n && i_select_b_n)) begin
			if (!i_read_not_write) begin
				in_r = i_data_lines;
			end else begin
				in_r = i_select_a_n ? reg_b : reg_a;
			end
		end
	end
	always @(posedge i_select_a_n) if (!i_read_not_write) reg_a = in_r;
	always @(posedge i_select_b_n) if (!i_read_not_write) reg_b = in_r;
	always @(posedge i_select_a_n or posedge i_select_b_n) if (!i_read_not_write) loads++;
	assign o_drive = !(i_select_a_n && i_select_b_n) && i_read_not_write;
	assign o_data_lines = o_drive ? in_r : ~in_r;
endmodule : ddp_dac_model

// ### ddp_host_port_bench.sv
`timescale 1ns/10ps
`include "ddp_map.svh"
module ddp_host_port_bench;
	logic i_clock, i_resetn, i_req, i_req_read, i_req_chan;
	logic [11:0] i_req_word;
	logic rdy, done, sa_n, sb_n, rnw, oe_n, drv;
	logic [11:0] rword, hdata, ddata;
	wire [11:0] bus = !oe_n ? hdata : ddata;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	// cycles from the taking edge until done is seen at a falling edge
	localparam logic [11:0] WR_SPAN = 12'(`DDP_SETUP_CYC + `DDP_WR_LOW_CYC + `DDP_HOLD_CYC);
	localparam logic [11:0] RD_SPAN = 12'(`DDP_SETUP_CYC + `DDP_RD_LOW_CYC + `DDP_TURN_CYC);
	ddp_host_port DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_req(i_req),
		.i_req_read(i_req_read), .i_req_chan(i_req_chan), .i_req_word(i_req_word),
		.o_ready(rdy), .o_done(done), .o_read_word(rword), .o_select_a_n(sa_n),
		.o_select_b_n(sb_n), .o_read_not_write(rnw), .i_data_lines(bus),
		.o_data_lines(hdata), .o_data_lines_oe_n(oe_n));
	ddp_dac_model dev (.i_select_a_n(sa_n), .i_select_b_n(sb_n), .i_read_not_write(rnw),
		.i_data_lines(bus), .o_data_lines(ddata), .o_drive(drv));
	task check(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one access, then its answer latency
	task access(input logic rd, input logic ch, input logic [11:0] w);
		int n;
		@(negedge i_clock);
		i_req = 1'b1;
		i_req_read = rd;
		i_req_chan = ch;
		i_req_word = w;
		@(negedge i_clock);
		i_req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 30) begin
			@(negedge i_clock);
			n++;
		end
		check("done delay", rd ? RD_SPAN : WR_SPAN, 12'(n));
	endtask : access
	task t_idle;
		check("idle pins", 12'h03E, {6'h00, rdy, sa_n, sb_n, rnw, oe_n, done});
	endtask : t_idle
	task t_write_read(input logic ch, input logic [11:0] w);
		access(1'b0, ch, w);
		check("out reg", w, ch ? dev.reg_b : dev.reg_a);
		access(1'b1, ch, 12'h000);
		check("readback", w, rword);
	endtask : t_write_read
	task t_back_to_back;
		int l;
		l = dev.loads;
		access(1'b0, 1'b0, 12'hFFF);
		access(1'b0, 1'b0, 12'h001);
		check("loads", 12'(l + 2), 12'(dev.loads));
		check("other chan", 12'h3F0, dev.reg_b);
		access(1'b1, 1'b0, 12'h000);
		check("readback a", 12'h001, rword);
	endtask : t_back_to_back
	task conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// clock and hang limit
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end
	// main sequence
	initial begin
		i_resetn = 1'b0;
		i_req = 1'b0;
		i_req_read = 1'b0;
		i_req_chan = 1'b0;
		i_req_word = 12'h000;
		repeat (8) @(negedge i_clock);
		i_resetn = 1'b1;
		t_idle();
		t_write_read(1'b0, 12'hA5C);
		t_write_read(1'b1, 12'h3F0);
		t_back_to_back();
		conclude();
	end
endmodule : ddp_host_port_bench
bind ddp_host_port ddp_host_port_asserts #(.DATA_W(DATA_W)) chk (.i_clock(i_clock),
	.i_resetn(i_resetn), .i_req(i_req), .i_req_read(i_req_read), .o_ready(o_ready),
	.o_done(o_done), .o_select_a_n(o_select_a_n), .o_select_b_n(o_select_b_n),
	.o_read_not_write(o_read_not_write), .o_data_lines(o_data_lines),
	.o_data_lines_oe_n(o_data_lines_oe_n));
